/* range_regs_pkg.sv */
// Package for the protected range and bus speed register bank
// Functional notes
// - The range mask register is readable and writable only in system management mode with range enable and lock set.
// - Bit 11 of the range mask register is the valid flag for both base and mask.
// - Bits 31 to 12 of the range mask register hold the address mask; 10 to 0 and 63 to 32 are reserved.
// - The bus speed register is read only, its 3-bit code gives 100/133/167/200/267/333 MHz.
// - On the enhanced generation, code 110B also reports a 400 MHz bus clock.
// - The range base register holds the base address in bits 31 to 12; the rest is reserved.
// - Base and mask are reachable in management mode only when range enable and lock are both set.
package range_regs_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] range_base_addr = 12'h0A0;
  localparam logic [11:0] range_mask_addr = 12'h0A1;
  localparam logic [11:0] bus_speed_addr = 12'h0CD;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int unsigned addr_lo = 12;
  localparam int unsigned addr_hi = 31;
  localparam int unsigned valid_bit = 11;
  localparam int unsigned code_w = 3;
  localparam int unsigned field_w = addr_hi - addr_lo + 1;
  localparam logic [field_w-1:0] field_rst = 20'h00000;

  // ----------------------------------------
  // Bus speed codes
  // ----------------------------------------
  localparam logic [2:0] spd_100 = 3'h5;
  localparam logic [2:0] spd_133 = 3'h1;
  localparam logic [2:0] spd_167 = 3'h3;
  localparam logic [2:0] spd_200 = 3'h2;
  localparam logic [2:0] spd_267 = 3'h0;
  localparam logic [2:0] spd_333 = 3'h4;
  localparam logic [2:0] spd_400 = 3'h6;

  typedef enum logic [2:0] {
    mhz_100, mhz_133, mhz_167, mhz_200, mhz_267, mhz_333, mhz_400
  } bus_speed_e;

  // Register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [63:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Range state shown to the rest of the core
  typedef struct packed {
    logic [field_w-1:0] base;
    logic [field_w-1:0] mask;
    logic valid;
  } range_state_s;

endpackage

/* bus_speed_encoder.sv */
// Encoder from bus speed selection to register code
`timescale 1ns/1ps
`default_nettype none
module bus_speed_encoder (
  // Selection
  input wire range_regs_pkg::bus_speed_e speed,
  input wire logic enhanced,
  // Code
  output logic [2:0] code
);

  // ----------------------------------------
  // Encoding
  // ----------------------------------------
  // 400 MHz is not encodable on the older generation; it falls back to 333
  always_comb begin
    case (speed)
      range_regs_pkg::mhz_100: code = range_regs_pkg::spd_100;
      range_regs_pkg::mhz_133: code = range_regs_pkg::spd_133;
      range_regs_pkg::mhz_167: code = range_regs_pkg::spd_167;
      range_regs_pkg::mhz_200: code = range_regs_pkg::spd_200;
      range_regs_pkg::mhz_267: code = range_regs_pkg::spd_267;
      range_regs_pkg::mhz_333: code = range_regs_pkg::spd_333;
      range_regs_pkg::mhz_400: code = enhanced ? range_regs_pkg::spd_400
                                               : range_regs_pkg::spd_333;
      default: code = range_regs_pkg::spd_267;
    endcase
  end

endmodule
`default_nettype wire

/* range_regs.sv */
// Protected range base/mask and bus speed register bank
`timescale 1ns/1ps
`default_nettype none
module range_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [63:0] reg_rdata,
  output logic reg_err,
  // Mode and feature control
  input wire logic system_management_mode,
  input wire logic range_enable,
  input wire logic feature_lock,
  // Bus speed straps
  input wire range_regs_pkg::bus_speed_e front_side_bus_speed,
  input wire logic enhanced_gen,
  // Range state
  output range_regs_pkg::range_state_s range_state
);

  // ----------------------------------------
  // Request bundling and synchronisers
  // ----------------------------------------
  range_regs_pkg::reg_req_s req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Mode and strap levels come from other logic domains: two flops first
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [2:0] spd1_q;
  logic [2:0] spd2_q;
  // The speed strap is a three-bit word: its bits may settle in the second flop on
  // different edges, so a code is only taken once two samples in a row agree
  logic [2:0] spd3_q;
  logic [2:0] spd_hold_q;
  wire spd_same = (spd2_q == spd3_q);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      spd1_q <= 3'h0;
      spd2_q <= 3'h0;
      spd3_q <= 3'h0;
      spd_hold_q <= 3'h0;
    end else begin
      sync1_q <= {enhanced_gen, feature_lock, range_enable, system_management_mode};
      sync2_q <= sync1_q;
      spd1_q <= front_side_bus_speed;
      spd2_q <= spd1_q;
      spd3_q <= spd2_q;
      if (spd_same) begin
        spd_hold_q <= spd2_q;
      end
    end
  end

  wire smm_s = sync2_q[0];
  wire en_s = sync2_q[1];
  wire lock_s = sync2_q[2];
  wire enh_s = sync2_q[3];
  range_regs_pkg::bus_speed_e spd_s;
  assign spd_s = range_regs_pkg::bus_speed_e'(spd_hold_q);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Both range registers are hidden unless enabled, locked and in SYSTEM_MANAGEMENT_MODE
  wire range_open = smm_s && en_s && lock_s;
  wire hit_base = (req.addr == range_regs_pkg::range_base_addr);
  wire hit_mask = (req.addr == range_regs_pkg::range_mask_addr);
  wire hit_spd = (req.addr == range_regs_pkg::bus_speed_addr);
  wire wr_base = req.wr && hit_base && range_open;
  wire wr_mask = req.wr && hit_mask && range_open;
  wire rd_range_ok = range_open;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [range_regs_pkg::field_w-1:0] base_q;
  logic [range_regs_pkg::field_w-1:0] mask_q;
  logic valid_q;
  wire [range_regs_pkg::field_w-1:0] wfield =
    req.wdata[range_regs_pkg::addr_hi:range_regs_pkg::addr_lo];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      base_q <= range_regs_pkg::field_rst;
      mask_q <= range_regs_pkg::field_rst;
      valid_q <= 1'b0;
    end else begin
      if (wr_base) begin
        base_q <= wfield;
      end
      if (wr_mask) begin
        mask_q <= wfield;
        valid_q <= req.wdata[range_regs_pkg::valid_bit];
      end
    end
  end

  // ----------------------------------------
  // Bus speed code
  // ----------------------------------------
  logic [2:0] code;
  bus_speed_encoder u_enc (
    .speed(spd_s),
    .enhanced(enh_s),
    .code(code)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Reserved bits stay zero because only the fields are ever placed
  logic [63:0] rd_val;
  logic rd_bad;
  always_comb begin
    rd_val = 64'h0000000000000000;
    rd_bad = 1'b0;
    if (hit_base && rd_range_ok) begin
      rd_val[range_regs_pkg::addr_hi:range_regs_pkg::addr_lo] = base_q;
    end else if (hit_mask && rd_range_ok) begin
      rd_val[range_regs_pkg::addr_hi:range_regs_pkg::addr_lo] = mask_q;
      rd_val[range_regs_pkg::valid_bit] = valid_q;
    end else if (hit_spd) begin
      rd_val[range_regs_pkg::code_w-1:0] = code;
    end else begin
      rd_bad = 1'b1;
    end
  end

  // Writes to the read-only speed register, to unmapped addresses or to range registers that are not open flag an error
  wire wr_bad = req.wr && !(wr_base || wr_mask);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 64'h0000000000000000;
      reg_err <= 1'b0;
      range_state <= '0;
    end else begin
      reg_rdata <= req.rd ? rd_val : 64'h0000000000000000;
      reg_err <= (req.rd && rd_bad) || wr_bad;
      range_state <= '{base: base_q, mask: mask_q, valid: valid_q};
    end
  end

endmodule
`default_nettype wire

/* range_regs_monitor.sv */
// Port checker for the range register bank
`timescale 1ns/1ps
`default_nettype none
module range_regs_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [63:0] reg_rdata,
  input wire logic reg_err,
  // Mode and state
  input wire logic system_management_mode,
  input wire logic range_enable,
  input wire logic enhanced_gen,
  input wire range_regs_pkg::range_state_s range_state
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 64'h0)
    else $error("read data without read");
  upper_zero_a: assert property (reg_rdata[63:32] == 32'h0)
    else $error("upper bits set");
  mask_low_a: assert property (reg_rd && reg_addr == 12'h0A1 |=> reg_rdata[10:0] == 11'h0)
    else $error("mask low bits set");
  speed_high_a: assert property (reg_rd && reg_addr == 12'h0CD |=> reg_rdata[63:3] == 61'h0)
    else $error("speed high bits set");
  speed_ro_a: assert property (reg_wr && reg_addr == 12'h0CD |=> reg_err)
    else $error("speed write not refused");
  mode_gate_a: assert property ((!system_management_mode)[*4] ##0 reg_wr |=> reg_err)
    else $error("write outside management mode");
  enable_gate_a: assert property ((!range_enable)[*4] ##0 reg_wr |=> reg_err)
    else $error("write without range enable");
  valid_track_a: assert property (reg_wr && reg_addr == 12'h0A1 ##1 !reg_err
    |=> range_state.valid == $past(reg_wdata[11], 2)) else $error("valid not stored");
  mask_track_a: assert property (reg_wr && reg_addr == 12'h0A1 ##1 !reg_err
    |=> range_state.mask == $past(reg_wdata[31:12], 2)) else $error("mask not stored");
  old_gen_a: assert property ((!enhanced_gen)[*4] ##0 reg_rd |=> reg_rdata[2:0] != 3'h6)
    else $error("400 code on older part");
endmodule
bind range_regs range_regs_monitor mon (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .reg_err, .system_management_mode, .range_enable, .enhanced_gen, .range_state);
`default_nettype wire

/* range_regs_test.sv */
// Self-checking bench for the range register bank
`timescale 1ns/1ps
`default_nettype none
module range_regs_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [63:0] reg_wdata = 64'h0, reg_rdata, base_m = 64'h0, mask_m = 64'h0, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0, reg_err, ok = 1'b0, enh = 1'b0;
  logic system_management_mode = 1'b0, range_enable = 1'b0, feature_lock = 1'b0;
  logic enhanced_gen = 1'b0;
  logic [2:0] spd = 3'h0;
  logic [2:0] codes [7] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h0, 3'h4, 3'h6};
  int khz [7] = '{100000, 133330, 166670, 200000, 266670, 333330, 400000};
  range_regs_pkg::bus_speed_e front_side_bus_speed = range_regs_pkg::mhz_100;
  range_regs_pkg::range_state_s range_state;
  int bad_count = 0, cmp_count = 0;
  range_regs dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_err,
    .system_management_mode, .range_enable, .feature_lock, .front_side_bus_speed,
    .enhanced_gen, .range_state);
  always #5 clk = ~clk;
  // ----------
  // Tasks
  // ----------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Software view of a speed code, using the fractional bus clocks in kHz rounded to 10 kHz
  function automatic int code_khz(input logic [2:0] c);
    case (c)
      3'h5: code_khz = 100000;
      3'h1: code_khz = 133330;
      3'h3: code_khz = 166670;
      3'h2: code_khz = 200000;
      3'h0: code_khz = 266670;
      3'h4: code_khz = 333330;
      3'h6: code_khz = 400000;
      default: code_khz = 0;
    endcase
  endfunction
  task automatic final_report;
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Five edges let the two-flop synchronisers settle before any access
  task automatic mode(input logic s, input logic e, input logic l);
    @(posedge clk);
    system_management_mode <= s;
    range_enable <= e;
    feature_lock <= l;
    front_side_bus_speed <= range_regs_pkg::bus_speed_e'(spd);
    enhanced_gen <= enh;
    ok = s & e & l;
    repeat (5) @(posedge clk);
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [63:0] v);
    logic [63:0] e;
    logic er;
    e = 64'h0;
    er = 1'b1;
    if ((a == 12'h0A0 || a == 12'h0A1) && ok) begin
      er = 1'b0;
      if (w && a == 12'h0A0) base_m = v & 64'h00000000FFFFF000;
      if (w && a == 12'h0A1) mask_m = v & 64'h00000000FFFFF800;
      if (!w) e = (a == 12'h0A0) ? base_m : mask_m;
    end else if (a == 12'h0CD && !w) begin
      er = 1'b0;
      e = {61'h0, (spd == 3'h6 && !enh) ? 3'h4 : codes[spd]};
    end
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    chk({63'h0, reg_err}, {63'h0, er});
  endtask
  initial begin
    #100000;
    bad_count++;
    final_report;
  end
  initial begin
    void'($urandom(32'h703844CE));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    mode(1'b0, 1'b1, 1'b1);
    acc(1'b0, 12'h0A1, 64'h0);
    acc(1'b1, 12'h0A1, {$urandom, $urandom});
    acc(1'b1, 12'h0CD, 64'h7);
    acc(1'b0, 12'h123, 64'h0);
    for (int k = 0; k < 14; k++) begin
      spd = 3'(k % 7);
      enh = k > 6;
      mode(1'b0, 1'b1, 1'b1);
      acc(1'b0, 12'h0CD, 64'h0);
      chk(64'(code_khz(reg_rdata[2:0])), 64'(khz[(spd == 3'h6 && !enh) ? 3'h5 : spd]));
    end
    for (int g = 0; g < 4; g++) begin
      mode(1'b1, 1'b1, 1'b1);
      acc(1'b0, 12'h0A1, 64'h0);
      acc(1'b0, 12'h0A0, 64'h0);
      d = {$urandom, $urandom};
      d[11] = g[0];
      acc(1'b1, 12'h0A1, d);
      acc(1'b1, 12'h0A0, {$urandom, $urandom});
      @(posedge clk);
      #1 chk(64'(range_state), {23'h0, base_m[31:12], mask_m[31:12], mask_m[11]});
      mode(g != 1, g != 2, g != 3);
      acc(1'b1, 12'h0A1, {$urandom, $urandom});
      acc(1'b1, 12'h0A0, {$urandom, $urandom});
    end
    final_report;
  end
endmodule
`default_nettype wire
